// file: common/dac_mux_pkg.sv
// Constants, register map and mode type for the dual-port converter input logic
package dac_mux_pkg;
    localparam int CLK_MHZ           = 25;
    localparam int DATA_W            = 14;
    localparam int PAIR_W            = 2 * DATA_W + 1;
    localparam int FIFO_DEPTH        = 8;
    localparam int LEVEL_W           = 4;
    localparam logic [13:0] CODE_MAX = 14'h3FFF;

    // Wishbone register map, byte addresses
    localparam int ADDR_W                = 8;
    localparam logic [7:0] CTRL_OFF      = 8'h00;
    localparam logic [7:0] STATUS_OFF    = 8'h04;
    localparam logic [7:0] CODE_OFF      = 8'h08;
    localparam logic [7:0] COUNT_OFF     = 8'h0C;

    // Control register fields
    localparam int CTRL_DRAIN_BIT        = 0;
    localparam logic CTRL_DRAIN_RESET    = 1'b1;

    // Status register fields
    localparam int ST_MODE_LSB           = 0;
    localparam int ST_MULT_OFF_BIT       = 2;
    localparam int ST_BAD_MODE_BIT       = 3;
    localparam int ST_OVERRUN_BIT        = 4;
    localparam int ST_UNDERRUN_BIT       = 5;
    localparam int ST_HALF_BIT           = 6;
    localparam int ST_LEVEL_LSB          = 8;

    // Alignment reset timing around an edge of the double-rate clock
    localparam int RESET_SETUP_NS        = 40;
    localparam int RESET_HOLD_NS         = 40;
    localparam int RESET_SETUP_CYC_RAW   = (RESET_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int RESET_SETUP_CYC       = (RESET_SETUP_CYC_RAW < 1) ? 1 : RESET_SETUP_CYC_RAW;
    localparam int RESET_HOLD_CYC_RAW    = (RESET_HOLD_NS * CLK_MHZ) / 1000;
    localparam int RESET_HOLD_CYC        = (RESET_HOLD_CYC_RAW < 1) ? 1 : RESET_HOLD_CYC_RAW;

    // Converter latch to output pins
    localparam int OUTPUT_PROP_NS        = 40;
    localparam int OUTPUT_PROP_CYC_RAW   = (OUTPUT_PROP_NS * CLK_MHZ) / 1000;
    localparam int OUTPUT_PROP_CYC       = (OUTPUT_PROP_CYC_RAW < 1) ? 1 : OUTPUT_PROP_CYC_RAW;

    typedef enum logic [1:0] {
        MODE_INTERLEAVED,
        MODE_PORT1,
        MODE_PORT2,
        MODE_PROHIBITED
    } mode_type;
endpackage

// file: design/bit_sync.sv
// Two flip-flop synchroniser for a group of pin inputs
module bit_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule

// file: design/sample_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
module sample_fifo #(
    parameter int WIDTH = 29,
    parameter int DEPTH = 8
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     in_valid_i,
    input  wire logic [WIDTH-1:0]         in_data_i,
    output logic                          in_ready_o,
    output logic                          out_valid_o,
    output logic      [WIDTH-1:0]         out_data_o,
    input  wire logic                     out_ready_i,
    output logic      [$clog2(DEPTH):0]   level_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count_q != (AW+1)'(DEPTH));
    assign out_valid_o = (count_q != '0);
    assign out_data_o  = mem_q[rd_ptr_q];
    assign level_o     = count_q;
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

// file: design/dac_input_mux.sv
// Dual-port converter input multiplexer with the clock multiplier off, Wishbone register slave
// How it works
// - Multiplier supply pin low means multiplier off; external clock paces converter updates.
// - With multiplier off, the two select pins steer the input multiplexer.
// - Selects 00 interleaved, 01 port 1, 10 port 2; 11 is prohibited.
// - Interleaved mode divides the external clock by two; rising half-rate edge loads both latches.
// - Lock pin shows a delayed copy of the half-rate latch clock.
// - On alignment reset release the half-rate clock stands high.
// - First edge after release drives it low; second drives it high and loads latches.
// - Edge too close after release is skipped; the next edge toggles instead.
// - Single-port mode loads the selected port's latch on every edge.
// - Converter latch takes the input latch on the next edge; output follows one stage later.
// - Samples are unsigned 0..16383; true output is code, complement is 16383 minus code.
// - Straight binary, bit 13 most significant, bit 0 least significant.
// - Interleaved converter latch updates twice per input latch edge.
//
// Design decisions made here: the Wishbone slave port and the register offsets.
module dac_input_mux (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        ext_clk2x_i,
    input  wire logic        align_reset_i,
    input  wire logic        mode_select_hi_i,
    input  wire logic        mode_select_lo_i,
    input  wire logic        multiplier_supply_pin_i,
    input  wire logic [13:0] port1_data_i,
    input  wire logic [13:0] port2_data_i,
    output logic             lock_or_half_clock_out_o,
    output logic      [13:0] dac_code_o,
    output logic      [13:0] current_out_true_o,
    output logic      [13:0] current_out_comp_o
);
    localparam int SYNC_W = 5 + 2 * dac_mux_pkg::DATA_W;

    logic [SYNC_W-1:0]                   sync_s;
    logic                                clk2x_s;
    logic                                align_s;
    logic                                sel_hi_s;
    logic                                sel_lo_s;
    logic                                mult_on_s;
    logic [13:0]                         port1_s;
    logic [13:0]                         port2_s;
    logic                                clk2x_prev_q;
    dac_mux_pkg::mode_type               mode_d;
    dac_mux_pkg::mode_type               mode_q;
    logic [3:0]                          low_cnt_q;
    logic                                edge_2x;
    logic                                edge_ok;
    logic                                active;
    logic                                half_q;
    logic                                load_req;
    logic [13:0]                         port1_latch_q;
    logic [13:0]                         port2_latch_q;
    logic [dac_mux_pkg::PAIR_W-1:0]      push_word;
    logic                                fifo_in_ready;
    logic                                fifo_out_valid;
    logic [dac_mux_pkg::PAIR_W-1:0]      fifo_out_data;
    logic                                fifo_out_ready;
    logic [dac_mux_pkg::LEVEL_W-1:0]     fifo_level;
    logic                                pending_q;
    logic [13:0]                         pending_code_q;
    logic                                primed_q;
    logic [13:0]                         conv_q;
    logic                                drain_q;
    logic                                bad_mode_q;
    logic                                overrun_q;
    logic                                underrun_q;
    logic [31:0]                         load_count_q;
    logic                                wb_req;
    logic                                wb_wr;
    logic                                clr_ok;
    logic [31:0]                         status_word;
    logic [31:0]                         read_d;

    bit_sync #(
        .WIDTH (SYNC_W)
    ) pin_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({ext_clk2x_i, align_reset_i, mode_select_hi_i, mode_select_lo_i,
                   multiplier_supply_pin_i, port1_data_i, port2_data_i}),
        .sync_o  (sync_s)
    );

    assign clk2x_s   = sync_s[SYNC_W-1];
    assign align_s   = sync_s[SYNC_W-2];
    assign sel_hi_s  = sync_s[SYNC_W-3];
    assign sel_lo_s  = sync_s[SYNC_W-4];
    assign mult_on_s = sync_s[SYNC_W-5];
    assign port1_s   = sync_s[27:14];
    assign port2_s   = sync_s[13:0];

    // Mode pins only steer the mux while the multiplier is off
    always_comb begin
        case ({sel_hi_s, sel_lo_s})
            2'b00:   mode_d = dac_mux_pkg::MODE_INTERLEAVED;
            2'b01:   mode_d = dac_mux_pkg::MODE_PORT1;
            2'b10:   mode_d = dac_mux_pkg::MODE_PORT2;
            default: mode_d = dac_mux_pkg::MODE_PROHIBITED;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q       <= dac_mux_pkg::MODE_INTERLEAVED;
            clk2x_prev_q <= 1'b0;
        end else begin
            mode_q       <= mode_d;
            clk2x_prev_q <= clk2x_s;
        end
    end

    assign active  = !mult_on_s && (mode_q != dac_mux_pkg::MODE_PROHIBITED);
    assign edge_2x = clk2x_s && !clk2x_prev_q;
    // An edge counts only once the release has met the setup window
    assign edge_ok = edge_2x && active && !align_s
                     && (low_cnt_q >= 4'(dac_mux_pkg::RESET_SETUP_CYC));

    always_ff @(posedge clk_i) begin
        if (rst_i || align_s) begin
            low_cnt_q <= '0;
        end else if (low_cnt_q < 4'(dac_mux_pkg::RESET_SETUP_CYC)) begin
            low_cnt_q <= low_cnt_q + 4'h1;
        end
    end

    // Half-rate latch clock: divide-by-two of the external clock
    always_ff @(posedge clk_i) begin
        if (rst_i || align_s) begin
            half_q <= 1'b1;
        end else if (edge_ok) begin
            half_q <= !half_q;
        end
    end

    // Interleaved loads on the half-rate rise, single-port on every edge
    assign load_req = edge_ok && ((mode_q != dac_mux_pkg::MODE_INTERLEAVED) || !half_q);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port1_latch_q <= '0;
            port2_latch_q <= '0;
        end else if (load_req && fifo_in_ready) begin
            if (mode_q != dac_mux_pkg::MODE_PORT2) begin
                port1_latch_q <= port1_s;
            end
            if (mode_q != dac_mux_pkg::MODE_PORT1) begin
                port2_latch_q <= port2_s;
            end
        end
    end

    // Word layout: pair flag, second sample (port 1 when paired), first sample out
    always_comb begin
        if (mode_q == dac_mux_pkg::MODE_INTERLEAVED) begin
            push_word = {1'b1, port1_s, port2_s};
        end else if (mode_q == dac_mux_pkg::MODE_PORT1) begin
            push_word = {1'b0, port1_s, port1_s};
        end else begin
            push_word = {1'b0, port2_s, port2_s};
        end
    end

    assign fifo_out_ready = edge_ok && drain_q && !pending_q;

    sample_fifo #(
        .WIDTH (dac_mux_pkg::PAIR_W),
        .DEPTH (dac_mux_pkg::FIFO_DEPTH)
    ) sample_buf (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (load_req),
        .in_data_i   (push_word),
        .in_ready_o  (fifo_in_ready),
        .out_valid_o (fifo_out_valid),
        .out_data_o  (fifo_out_data),
        .out_ready_i (fifo_out_ready),
        .level_o     (fifo_level)
    );

    // Converter latch: one sample per external edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_q         <= '0;
            pending_q      <= 1'b0;
            pending_code_q <= '0;
        end else if (edge_ok && drain_q) begin
            if (pending_q) begin
                conv_q    <= pending_code_q;
                pending_q <= 1'b0;
            end else if (fifo_out_valid) begin
                conv_q         <= fifo_out_data[13:0];
                pending_q      <= fifo_out_data[dac_mux_pkg::PAIR_W-1];
                pending_code_q <= fifo_out_data[27:14];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || align_s) begin
            primed_q <= 1'b0;
        end else if (load_req && fifo_in_ready) begin
            primed_q <= 1'b1;
        end
    end

    // Output stage after the converter latch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dac_code_o         <= '0;
            current_out_true_o <= '0;
            current_out_comp_o <= dac_mux_pkg::CODE_MAX;
        end else begin
            dac_code_o         <= conv_q;
            current_out_true_o <= conv_q;
            current_out_comp_o <= dac_mux_pkg::CODE_MAX - conv_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_or_half_clock_out_o <= 1'b0;
        end else begin
            lock_or_half_clock_out_o <= !mult_on_s && half_q;
        end
    end

    // Wishbone slave: one wait state, every access acknowledged
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // Writes land at the edge where the master samples ack high
    assign wb_wr  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
    assign clr_ok = wb_wr && (wb_adr_i == dac_mux_pkg::STATUS_OFF);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drain_q <= dac_mux_pkg::CTRL_DRAIN_RESET;
        end else if (wb_wr && (wb_adr_i == dac_mux_pkg::CTRL_OFF)) begin
            drain_q <= wb_dat_i[dac_mux_pkg::CTRL_DRAIN_BIT];
        end
    end

    // Sticky flags: write one clears, a new event in the same cycle wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bad_mode_q <= 1'b0;
            overrun_q  <= 1'b0;
            underrun_q <= 1'b0;
        end else begin
            if (!mult_on_s && (mode_q == dac_mux_pkg::MODE_PROHIBITED)) begin
                bad_mode_q <= 1'b1;
            end else if (clr_ok && wb_dat_i[dac_mux_pkg::ST_BAD_MODE_BIT]) begin
                bad_mode_q <= 1'b0;
            end
            if (load_req && !fifo_in_ready) begin
                overrun_q <= 1'b1;
            end else if (clr_ok && wb_dat_i[dac_mux_pkg::ST_OVERRUN_BIT]) begin
                overrun_q <= 1'b0;
            end
            if (fifo_out_ready && !fifo_out_valid && primed_q) begin
                underrun_q <= 1'b1;
            end else if (clr_ok && wb_dat_i[dac_mux_pkg::ST_UNDERRUN_BIT]) begin
                underrun_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            load_count_q <= '0;
        end else if (load_req && fifo_in_ready) begin
            load_count_q <= load_count_q + 32'h1;
        end
    end

    always_comb begin
        status_word = '0;
        status_word[dac_mux_pkg::ST_MODE_LSB +: 2]    = mode_q;
        status_word[dac_mux_pkg::ST_MULT_OFF_BIT]     = !mult_on_s;
        status_word[dac_mux_pkg::ST_BAD_MODE_BIT]     = bad_mode_q;
        status_word[dac_mux_pkg::ST_OVERRUN_BIT]      = overrun_q;
        status_word[dac_mux_pkg::ST_UNDERRUN_BIT]     = underrun_q;
        status_word[dac_mux_pkg::ST_HALF_BIT]         = half_q;
        status_word[dac_mux_pkg::ST_LEVEL_LSB +: 4]   = fifo_level;
    end

    always_comb begin
        if (wb_adr_i == dac_mux_pkg::CTRL_OFF) begin
            read_d = {31'h0, drain_q};
        end else if (wb_adr_i == dac_mux_pkg::STATUS_OFF) begin
            read_d = status_word;
        end else if (wb_adr_i == dac_mux_pkg::CODE_OFF) begin
            read_d = {18'h0, conv_q};
        end else if (wb_adr_i == dac_mux_pkg::COUNT_OFF) begin
            read_d = load_count_q;
        end else begin
            read_d = 32'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (wb_req && !wb_we_i) begin
            wb_dat_o <= read_d;
        end
    end

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence release_s;
        $fell(align_s) ##0 !mult_on_s;
    endsequence

    sequence first_edge_s;
        edge_ok && half_q;
    endsequence

    mult_on_lock_a: assert property (mult_on_s |=> !lock_or_half_clock_out_o)
        else $error("lock pin high while multiplier active");
    mode_decode_a: assert property ((mult_on_s == 1'b0) && (sel_hi_s == 1'b0) && (sel_lo_s == 1'b1)
        |=> mode_q == dac_mux_pkg::MODE_PORT1)
        else $error("mode pins decoded wrongly");
    prohibited_idle_a: assert property (mode_q == dac_mux_pkg::MODE_PROHIBITED |-> !load_req)
        else $error("latch load in prohibited mode");
    pair_load_a: assert property (mode_q == dac_mux_pkg::MODE_INTERLEAVED && edge_ok
        |-> load_req == !half_q)
        else $error("interleaved load not on half clock rise");
    // The release cycle is excluded: the lock pin is still held low by reset there
    lock_copy_a: assert property (!mult_on_s && !rst_i |=> lock_or_half_clock_out_o == $past(half_q))
        else $error("lock pin does not follow half clock");
    release_high_a: assert property (release_s |-> half_q ##1 lock_or_half_clock_out_o)
        else $error("half clock not high after alignment release");
    first_edge_low_a: assert property (first_edge_s |=> !half_q)
        else $error("first edge did not drive half clock low");
    hold_skip_a: assert property (edge_2x && (low_cnt_q < 4'(dac_mux_pkg::RESET_SETUP_CYC))
        |=> $stable(half_q))
        else $error("edge inside reset window toggled half clock");
    single_load_a: assert property (mode_q == dac_mux_pkg::MODE_PORT2 && load_req && fifo_in_ready
        |=> port2_latch_q == $past(port2_s))
        else $error("single-port latch not loaded");
    output_stage_a: assert property (##1 dac_code_o == $past(conv_q))
        else $error("output stage does not follow converter latch");
    comp_sum_a: assert property (##1 (15'(current_out_true_o) + 15'(current_out_comp_o))
        == 15'(dac_mux_pkg::CODE_MAX))
        else $error("complementary outputs do not sum to full scale");
    second_half_a: assert property (edge_ok && drain_q && pending_q
        |=> conv_q == $past(pending_code_q) && !pending_q)
        else $error("second interleaved sample not presented");
endmodule

// file: sim/sample_source.sv
// Parallel sample source: alignment pulse, double-rate clock and paired port data
module sample_source (
    input  wire logic        clk_i,
    input  wire logic        start_i,
    output logic             ext_clk2x_o,
    output logic             align_reset_o,
    output logic      [13:0] port1_data_o,
    output logic      [13:0] port2_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        run_q   = 1'b0;
    logic        clk2x_q = 1'b0;
    logic        align_q = 1'b0;
    logic        odd_q   = 1'b0;
    logic [3:0]  wait_q  = 4'h0;
    logic [1:0]  phase_q = 2'h0;
    logic [13:0] pair_q  = 14'h0000;
    assign ext_clk2x_o   = clk2x_q;
    assign align_reset_o = align_q;
    assign port1_data_o  = 14'h1000 + pair_q;
    assign port2_data_o  = 14'h2000 + pair_q;
    always_ff @(posedge clk_i) begin
        if (start_i) begin
            align_q <= 1'b1;
            clk2x_q <= 1'b0;
            wait_q  <= 4'h8;
            phase_q <= 2'h0;
            odd_q   <= 1'b0;
            run_q   <= 1'b1;
        end else if (wait_q != 4'h0) begin
            wait_q  <= wait_q - 4'h1;
            align_q <= (wait_q > 4'h6);
        end else if (run_q) begin
            phase_q <= phase_q + 2'h1;
            if (phase_q == 2'h3) begin
                clk2x_q <= ~clk2x_q;
                if (clk2x_q) odd_q <= ~odd_q;
                // New pair after the loading edge, on the following fall
                if (clk2x_q && odd_q) pair_q <= pair_q + 14'h0001;
            end
        end
    end
endmodule

// file: sim/tb_dac_input_mux.sv
// Self-checking bench for the dual-port converter input multiplexer
module tb_dac_input_mux;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic        hi    = 1'b0;
    logic        lo    = 1'b0;
    logic        mult  = 1'b0;
    logic        start = 1'b0;
    logic [7:0]  adr   = 8'h00;
    logic [31:0] wdat  = 32'h0;
    logic        clk2x, align, lock, ack;
    logic [13:0] p1, p2, code, ctrue, ccomp, v, e, prev;
    logic [31:0] dat_o, rdat, cnt;
    int          failures  = 0;
    int          tests_run = 0;
    // Mode pins beside expected status bits mult_off and mode
    logic [4:0]  rows [3] = '{5'b00100, 5'b01101, 5'b10110};
    dac_input_mux i_dac_input_mux (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .ext_clk2x_i(clk2x),
        .align_reset_i(align), .mode_select_hi_i(hi), .mode_select_lo_i(lo), .multiplier_supply_pin_i(mult),
        .port1_data_i(p1), .port2_data_i(p2), .lock_or_half_clock_out_o(lock), .dac_code_o(code),
        .current_out_true_o(ctrue), .current_out_comp_o(ccomp));
    sample_source i_sample_source (.clk_i(clk_i), .start_i(start), .ext_clk2x_o(clk2x),
        .align_reset_o(align), .port1_data_o(p1), .port2_data_o(p2));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) failures++;
        if (n >= 20) summarize();
        @(posedge clk_i);
    endtask
    task automatic next_code(output logic [13:0] c);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (code === prev && n < 100);
        if (n >= 100) failures++;
        if (n >= 100) summarize();
        c = code;
        prev = code;
        check("true", ctrue, code);
        check("comp", ccomp, 14'h3FFF - code);
    endtask
    // Interleaved: port 2 sample, then port 1 of the same pair
    function automatic logic [13:0] exp_next(input logic [1:0] m, input logic [13:0] c);
        if (m != 2'b00) return c + 14'h0001;
        if (c[13:12] == 2'b10) return {2'b01, c[11:0]};
        return {2'b10, c[11:0] + 12'h001};
    endfunction
    initial begin
        tick(2);
        rst_i <= 1'b0;
        tick(1);
        check("lock", lock, 1'b0);
        check("code", code, 14'h0000);
        check("comp", ccomp, 14'h3FFF);
        prev = code;
        wb(1'b0, 8'h10, 32'h0);
        check("unmapped", rdat, 32'h0);
        for (int r = 0; r < 3; r++) begin
            {hi, lo} <= rows[r][4:3];
            start <= 1'b1;
            tick(1);
            start <= 1'b0;
            if (r == 0) begin
                tick(11);
                check("lock", lock, 1'b1);
                tick(9);
                check("lock", lock, 1'b0);
                tick(8);
                check("lock", lock, 1'b1);
            end
            repeat (3) next_code(v);
            for (int k = 0; k < 6; k++) begin
                e = exp_next(rows[r][4:3], v);
                next_code(v);
                check("code", v, e);
            end
            wb(1'b0, 8'h04, 32'h0);
            check("status", rdat[2:0], rows[r][2:0]);
        end
        {hi, lo} <= 2'b11;
        tick(4);
        wb(1'b0, 8'h0C, 32'h0);
        cnt = rdat;
        tick(60);
        wb(1'b0, 8'h0C, 32'h0);
        check("count", rdat, cnt);
        wb(1'b0, 8'h04, 32'h0);
        check("bad_mode", rdat[3], 1'b1);
        {hi, lo} <= 2'b00;
        mult <= 1'b1;
        tick(4);
        wb(1'b0, 8'h0C, 32'h0);
        cnt = rdat;
        tick(60);
        check("lock", lock, 1'b0);
        wb(1'b0, 8'h08, 32'h0);
        check("code_reg", rdat, {18'h0, code});
        wb(1'b0, 8'h0C, 32'h0);
        check("count", rdat, cnt);
        mult <= 1'b0;
        wb(1'b1, 8'h00, 32'h0);
        tick(300);
        wb(1'b0, 8'h04, 32'h0);
        check("overrun", rdat[4], 1'b1);
        check("level", rdat[11:8], 4'h8);
        wb(1'b1, 8'h00, 32'h1);
        wb(1'b0, 8'h00, 32'h0);
        check("ctrl", rdat[0], 1'b1);
        tick(40);
        wb(1'b1, 8'h04, 32'h10);
        wb(1'b0, 8'h04, 32'h0);
        check("overrun_clr", rdat[4], 1'b0);
        check("bad_mode", rdat[3], 1'b1);
        summarize();
    end
endmodule
